// [design/dmp_acc_round.sv]
// rounds a wide accumulator to its 16-bit upper word
`timescale 1ns/1ps
module dmp_acc_round
	import dmp_pkg::*;
#(
	parameter int ACC_W = 40
)
(
	dmp_rnd_if.rnd bus
);
	// ------------------------------------------------------------
	// elaboration check
	// ------------------------------------------------------------
	// the upper word lives at bits 31:16, so narrower cannot serve
	if (ACC_W < 32)
	begin : g_chk
		$error("dmp_acc_round: ACC_W must be at least 32");
	end

	// ------------------------------------------------------------
	// round half up on bit 15
	// ------------------------------------------------------------
	// note: no saturation on wrap, a 7fff word with bit 15 set rolls over
	always_comb
	begin
		bus.word = bus.acc[31:16] + {15'h0000, bus.acc[15]};
	end
endmodule

// [design/dmp_exec.sv]
// executor for double-word move, page register load and prefetch-and-store
//
// What this block does
// - direct move copies even pair to even pair
// - pointer addresses low word, high word follows
// - pointer steps by four bytes when modified
// - move decodes prefix, destination, mode, source fields
// - move is one word, two cycles when direct, three or more when indirect
// - stack pop is pre-decrement move from stack pointer
// - literal page load keeps 10, 9, 8 bits
// - register page load copies low source bits
// - literal page load: select then ten-bit literal
// - register page load: select, zeros, source register
// - page loads are word, one cycle, flags untouched
// - optional x prefetch into w4-w7, pointer adjust
// - optional y prefetch likewise, four-bit operation field
// - offset mode adds w12, pointer stays unchanged
// - no accumulator math, named one picks counterpart
// - other accumulator rounded to w13 or [w13]+=2
// - prefetch-store fields: acc, x, y, ops, write-back
// - write-back field: register, memory, or none
// - accumulators are forty bits wide
`timescale 1ns/1ps
`include "dmp_params.svh"
module dmp_exec
	import dmp_pkg::*;
#(
	parameter int ACC_W = 40
)
(
	input wire logic sys_clk,
	input wire logic rstn,
	input wire logic instr_valid,
	input wire logic [23:0] instr_word,
	input wire logic [ACC_W-1:0] accumulator_a,
	input wire logic [ACC_W-1:0] accumulator_b,
	input wire logic mem_ack,
	input wire logic [15:0] mem_rdata,
	input wire logic ld_en,
	input wire logic [3:0] ld_idx,
	input wire logic [15:0] ld_data,
	input wire logic [3:0] rd_idx,
	output logic busy_r,
	output logic done_r,
	output logic illegal_r,
	output logic mem_rd_r,
	output logic mem_wr_r,
	output logic [15:0] mem_addr_r,
	output logic [15:0] mem_wdata_r,
	output logic [9:0] data_read_page_reg,
	output logic [8:0] data_write_page_reg,
	output logic [7:0] table_page_reg,
	output logic [15:0] rd_data_r
);
	// ------------------------------------------------------------
	// reset release and storage
	// ------------------------------------------------------------
	logic [1:0] rst_sync_r; // release synchroniser
	logic rst_n; // internal reset
	dmp_word_t w_r [16]; // working registers
	dmp_state_t state_r; // sequencer state
	dmp_state_t state_nxt; // next state
	logic [23:0] ins_r; // instruction held while it runs

	always_ff @(posedge sys_clk or negedge rstn)
	begin
		if (!rstn)
			rst_sync_r <= 2'h0;
		else
			rst_sync_r <= {rst_sync_r[0], 1'b1};
	end
	assign rst_n = rst_sync_r[1];

	// ------------------------------------------------------------
	// decode of the live instruction
	// ------------------------------------------------------------
	logic [23:0] ins; // new word when idle, held word otherwise
	logic accept; // instruction taken this edge
	logic is_mvd, is_pgl, is_pgr, is_psa; // instruction class
	logic [3:0] dnd, ssr; // move destination and source register
	logic [2:0] am; // move source mode
	logic [3:0] xd, yd, xp, yp; // prefetch destinations and pointers
	logic [2:0] xo, yo; // prefetch operation, low three bits
	logic x_on, y_on, x_off, y_off, wb_on; // prefetch/write-back enables
	dmp_word_t x_ea, y_ea, x_upd, y_upd; // addresses and new pointers
	dmp_word_t mvd_ea, mvd_ptr; // move address and new pointer
	logic [1:0] aa; // write-back target field
	dmp_rnd_if #(.ACC_W(ACC_W)) rnd_bus ();

	assign ins = (state_r == DMP_IDLE) ? instr_word : ins_r;
	assign accept = (state_r == DMP_IDLE) && instr_valid;

	// field extraction; bit 11 and bit 7 of the move must be zero
	always_comb
	begin
		is_mvd = (ins[23:12] == `DMP_MVD_OPC) && !ins[11] && !ins[7];
		is_pgl = (ins[23:12] == `DMP_PGL_OPC);
		is_pgr = (ins[23:12] == `DMP_PGR_OPC) && (ins[9:4] == 6'h00);
		is_psa = (ins[23:16] == `DMP_PSA_OPC) && !ins[14];
		dnd = {ins[10:8], 1'b0};
		am = ins[6:4];
		ssr = ins[3:0];
		xd = `DMP_W_BASE_DST + {2'h0, ins[13:12]};
		yd = `DMP_W_BASE_DST + {2'h0, ins[11:10]};
		xp = `DMP_W_X0 + {3'h0, ins[9]};
		yp = `DMP_W_Y0 + {3'h0, ins[5]};
		xo = ins[8:6];
		yo = ins[4:2];
		aa = ins[1:0];
	end

	// prefetch address arithmetic; op x100 is "none" or "offset"
	always_comb
	begin
		x_off = ins[9] && (xo == `DMP_PF_OFFS);
		y_off = ins[5] && (yo == `DMP_PF_OFFS);
		x_on = is_psa && !(!ins[9] && (xo == `DMP_PF_NONE));
		y_on = is_psa && !(!ins[5] && (yo == `DMP_PF_NONE));
		wb_on = is_psa && (aa == `DMP_WB_REG || aa == `DMP_WB_MEM);
		x_ea = x_off ? w_r[xp] + w_r[`DMP_W_OFFS] : w_r[xp];
		y_ea = y_off ? w_r[yp] + w_r[`DMP_W_OFFS] : w_r[yp];
		// codes 1..3 add 2/4/6, codes 5..7 subtract 6/4/2
		x_upd = xo[2] ? w_r[xp] - {12'h000, 3'h4 - xo[1:0], 1'b0} : w_r[xp] + {13'h0000, xo[1:0], 1'b0};
		y_upd = yo[2] ? w_r[yp] - {12'h000, 3'h4 - yo[1:0], 1'b0} : w_r[yp] + {13'h0000, yo[1:0], 1'b0};
		// stack pop is simply mode pre-decrement with source w15
		unique case (am)
			`DMP_AM_POSTDEC, `DMP_AM_PREDEC: mvd_ptr = w_r[ssr] - `DMP_MVD_STEP;
			`DMP_AM_POSTINC, `DMP_AM_PREINC: mvd_ptr = w_r[ssr] + `DMP_MVD_STEP;
			default: mvd_ptr = w_r[ssr];
		endcase
		mvd_ea = (am == `DMP_AM_PREDEC || am == `DMP_AM_PREINC) ? mvd_ptr : w_r[ssr];
	end

	// the named accumulator is only a selector: its partner is stored
	assign rnd_bus.acc = ins[15] ? accumulator_a : accumulator_b;
	dmp_acc_round #(.ACC_W(ACC_W)) u_round (.bus(rnd_bus));

	// ------------------------------------------------------------
	// sequencer
	// ------------------------------------------------------------
	logic stage_done; // current stage finishes this edge
	logic adv; // state advances this edge
	dmp_state_t after_x_st, after_y_st; // chained prefetch stages

	always_comb
	begin
		after_y_st = wb_on ? DMP_WB : DMP_IDLE;
		after_x_st = y_on ? DMP_PF_Y : after_y_st;
		unique case (state_r)
			DMP_MVD_LO, DMP_MVD_HI, DMP_PF_X, DMP_PF_Y: stage_done = mem_ack;
			DMP_WB: stage_done = (aa == `DMP_WB_REG) || mem_ack;
			DMP_DIR2: stage_done = 1'b1;
			default: stage_done = 1'b0;
		endcase
		state_nxt = state_r;
		unique case (state_r)
			DMP_IDLE:
			begin
				if (accept && is_mvd)
					state_nxt = (am == `DMP_AM_DIRECT) ? DMP_DIR2 : DMP_MVD_LO;
				else if (accept && is_psa)
					state_nxt = x_on ? DMP_PF_X : after_x_st;
			end
			DMP_MVD_LO: state_nxt = stage_done ? DMP_MVD_HI : state_r;
			DMP_PF_X: state_nxt = stage_done ? after_x_st : state_r;
			DMP_PF_Y: state_nxt = stage_done ? after_y_st : state_r;
			default: state_nxt = stage_done ? DMP_IDLE : state_r;
		endcase
		adv = accept || stage_done;
	end

	// state and held instruction
	always_ff @(posedge sys_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			state_r <= DMP_IDLE;
			ins_r <= 24'h000000;
		end
		else
		begin
			state_r <= state_nxt;
			if (accept)
				ins_r <= instr_word;
		end
	end

	// handshake flags: busy while a multi-cycle job runs
	always_ff @(posedge sys_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			busy_r <= 1'b0;
			done_r <= 1'b0;
			illegal_r <= 1'b0;
		end
		else
		begin
			busy_r <= (state_nxt != DMP_IDLE);
			done_r <= adv && (state_nxt == DMP_IDLE) && !(accept && !(is_mvd || is_pgl || is_pgr || is_psa));
			illegal_r <= accept && !(is_mvd || is_pgl || is_pgr || is_psa);
		end
	end

	// ------------------------------------------------------------
	// data memory port, set up as each stage is entered
	// ------------------------------------------------------------
	always_ff @(posedge sys_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			mem_rd_r <= 1'b0;
			mem_wr_r <= 1'b0;
			mem_addr_r <= `DMP_RESET_W;
			mem_wdata_r <= `DMP_RESET_W;
		end
		else if (adv)
		begin
			mem_rd_r <= state_nxt inside {DMP_MVD_LO, DMP_MVD_HI, DMP_PF_X, DMP_PF_Y};
			mem_wr_r <= (state_nxt == DMP_WB) && (aa == `DMP_WB_MEM);
			mem_wdata_r <= rnd_bus.word;
			unique case (state_nxt)
				DMP_MVD_LO: mem_addr_r <= mvd_ea;
				DMP_MVD_HI: mem_addr_r <= mem_addr_r + `DMP_WORD_STEP;
				DMP_PF_X: mem_addr_r <= x_ea;
				DMP_PF_Y: mem_addr_r <= y_ea;
				DMP_WB: mem_addr_r <= w_r[`DMP_W_WB];
				default: mem_addr_r <= mem_addr_r;
			endcase
		end
	end

	// ------------------------------------------------------------
	// working register write ports
	// ------------------------------------------------------------
	// port 0 carries loaded data, the even word of a direct move or the rounded word, and wins over port 1 (pointers, or the odd word of a direct move);
	// only working and page registers are ever written, so the
	// status flags of the core stay as they were
	logic wp0_en, wp1_en; // write strobes
	logic [3:0] wp0_idx, wp1_idx; // write targets
	dmp_word_t wp0_dat, wp1_dat; // write data

	always_comb
	begin
		wp0_en = 1'b0;
		wp1_en = 1'b0;
		wp0_idx = dnd;
		wp1_idx = ssr;
		wp0_dat = mem_rdata;
		wp1_dat = mvd_ptr;
		unique case (state_r)
			DMP_IDLE:
			begin
				if (accept && is_mvd && am == `DMP_AM_DIRECT)
				begin
					wp0_en = 1'b1;
					wp0_dat = w_r[{ssr[3:1], 1'b0}];
					wp1_en = 1'b1;
					wp1_idx = dnd | 4'h1;
					wp1_dat = w_r[{ssr[3:1], 1'b1}];
				end
				else if (accept && is_mvd)
					wp1_en = (am != `DMP_AM_IND);
			end
			DMP_MVD_LO: wp0_en = mem_ack;
			DMP_MVD_HI:
			begin
				wp0_en = mem_ack;
				wp0_idx = dnd | 4'h1;
			end
			DMP_PF_X:
			begin
				wp0_en = mem_ack;
				wp0_idx = xd;
				wp1_en = mem_ack && !x_off && (xo[1:0] != 2'h0);
				wp1_idx = xp;
				wp1_dat = x_upd;
			end
			DMP_PF_Y:
			begin
				wp0_en = mem_ack;
				wp0_idx = yd;
				wp1_en = mem_ack && !y_off && (yo[1:0] != 2'h0);
				wp1_idx = yp;
				wp1_dat = y_upd;
			end
			DMP_WB:
			begin
				wp0_en = (aa == `DMP_WB_REG);
				wp0_idx = `DMP_W_WB;
				wp0_dat = rnd_bus.word;
				wp1_en = (aa == `DMP_WB_MEM) && mem_ack;
				wp1_idx = `DMP_W_WB;
				wp1_dat = w_r[`DMP_W_WB] + `DMP_WORD_STEP;
			end
			default:
			begin
				wp0_en = 1'b0;
			end
		endcase
	end

	// one flop set per working register; the core's load port has the
	// lowest priority and is meant for use while the block is idle
	for (genvar gi = 0; gi < 16; gi++)
	begin : g_wreg
		always_ff @(posedge sys_clk or negedge rst_n)
		begin
			if (!rst_n)
				w_r[gi] <= `DMP_RESET_W;
			else if (wp0_en && wp0_idx == 4'(gi))
				w_r[gi] <= wp0_dat;
			else if (wp1_en && wp1_idx == 4'(gi))
				w_r[gi] <= wp1_dat;
			else if (ld_en && ld_idx == 4'(gi))
				w_r[gi] <= ld_data;
		end
	end

	// registered read-back of one working register
	always_ff @(posedge sys_clk or negedge rst_n)
	begin
		if (!rst_n)
			rd_data_r <= `DMP_RESET_W;
		else
			rd_data_r <= w_r[rd_idx];
	end

	// ------------------------------------------------------------
	// page registers, written in the accept cycle
	// ------------------------------------------------------------
	dmp_word_t pg_src; // literal or source register
	assign pg_src = is_pgl ? {6'h00, ins[9:0]} : w_r[ssr];

	always_ff @(posedge sys_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			data_read_page_reg <= 10'h000;
			data_write_page_reg <= 9'h000;
			table_page_reg <= 8'h00;
		end
		else if (accept && (is_pgl || is_pgr))
		begin
			// select code 11 writes nothing
			unique case (ins[11:10])
				`DMP_PG_READ: data_read_page_reg <= pg_src[`DMP_PG_RD_W-1:0];
				`DMP_PG_WRITE: data_write_page_reg <= pg_src[`DMP_PG_WR_W-1:0];
				`DMP_PG_TABLE: table_page_reg <= pg_src[`DMP_PG_TB_W-1:0];
				default: table_page_reg <= table_page_reg;
			endcase
		end
	end

	// ------------------------------------------------------------
	// checks
	// ------------------------------------------------------------
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (!rst_n);

	sequence s_mvd_direct_go;
		accept && is_mvd && am == `DMP_AM_DIRECT;
	endsequence
	sequence s_two_busy_then_free;
		(busy_r && !done_r) ##1 (done_r && !busy_r);
	endsequence

	a_mvd_direct_timing: assert property (s_mvd_direct_go |=> s_two_busy_then_free)
		else $error("direct double move did not take two cycles");
	a_mvd_pair_copy: assert property (s_mvd_direct_go |=> w_r[$past(dnd) | 4'h1] == $past(w_r[ssr | 4'h1]))
		else $error("odd half of pair not copied");
	a_mvd_ptr_step: assert property (accept && is_mvd && am == `DMP_AM_POSTINC && ssr != dnd && ssr != (dnd | 4'h1)
		|=> w_r[$past(ssr)] == $past(mvd_ptr) && $past(mvd_ptr) == $past(w_r[ssr]) + 16'h0004)
		else $error("pointer not stepped by four");
	a_mvd_hi_addr: assert property (state_r == DMP_MVD_LO && mem_ack |=> mem_addr_r == $past(mem_addr_r) + 16'h0002)
		else $error("high word not at next address");
	a_pop_addr: assert property (accept && is_mvd && am == `DMP_AM_PREDEC && ssr == `DMP_W_SP
		|=> mem_rd_r && mem_addr_r == $past(w_r[`DMP_W_SP]) - 16'h0004)
		else $error("pop did not pre-decrement stack pointer");
	a_page_one_cycle: assert property (accept && is_pgl && ins[11:10] == `DMP_PG_WRITE
		|=> done_r && !busy_r && data_write_page_reg == $past(instr_word[8:0]))
		else $error("literal write-page load wrong");
	a_page_reg_copy: assert property (accept && is_pgr && ins[11:10] == `DMP_PG_TABLE
		|=> table_page_reg == $past(pg_src[7:0]) && $stable(data_read_page_reg))
		else $error("table page load from register wrong");
	a_offset_keeps_ptr: assert property (state_r == DMP_PF_Y && mem_ack && y_off |=> $stable(w_r[`DMP_W_Y0 + 4'h1]))
		else $error("offset prefetch changed its pointer");
	a_wb_reg_round: assert property (state_r == DMP_WB && aa == `DMP_WB_REG
		|=> w_r[`DMP_W_WB] == $past(rnd_bus.word) && !busy_r)
		else $error("rounded word not stored to w13");
	a_wb_mem_incr: assert property (state_r == DMP_WB && aa == `DMP_WB_MEM && mem_ack
		|=> w_r[`DMP_W_WB] == $past(mem_addr_r) + 16'h0002)
		else $error("w13 not post-incremented by two");
	a_x_prefetch_dst: assert property (state_r == DMP_PF_X && mem_ack |=> w_r[$past(xd)] == $past(mem_rdata))
		else $error("x prefetch data not stored");
endmodule

// [design/dmp_params.svh]
// constants for the double-word move, page load and prefetch executor
`ifndef DMP_PARAMS_SVH
`define DMP_PARAMS_SVH

// opcode prefixes and where they sit
`define DMP_MVD_OPC 12'hbe0
`define DMP_PGL_OPC 12'hfec
`define DMP_PGR_OPC 12'hfed
`define DMP_PSA_OPC 8'hc7
// double-word move source modes
`define DMP_AM_DIRECT 3'h0
`define DMP_AM_IND 3'h1
`define DMP_AM_POSTDEC 3'h2
`define DMP_AM_POSTINC 3'h3
`define DMP_AM_PREDEC 3'h4
`define DMP_AM_PREINC 3'h5
`define DMP_MVD_STEP 16'h0004
// page select codes
`define DMP_PG_READ 2'h0
`define DMP_PG_WRITE 2'h1
`define DMP_PG_TABLE 2'h2
`define DMP_PG_RD_W 10
`define DMP_PG_WR_W 9
`define DMP_PG_TB_W 8
// prefetch operations and fixed registers
`define DMP_PF_NONE 3'h4
`define DMP_PF_OFFS 3'h4
`define DMP_W_BASE_DST 4'h4
`define DMP_W_X0 4'h8
`define DMP_W_Y0 4'ha
`define DMP_W_OFFS 4'hc
`define DMP_W_WB 4'hd
`define DMP_W_SP 4'hf
`define DMP_WB_REG 2'h0
`define DMP_WB_MEM 2'h1
`define DMP_WORD_STEP 16'h0002
`define DMP_RESET_W 16'h0000

`endif

// [design/dmp_pkg.sv]
// types shared by the executor modules
package dmp_pkg;
	typedef logic [15:0] dmp_word_t;
	typedef enum logic [2:0]
	{
		DMP_IDLE = 3'b000,
		DMP_MVD_LO = 3'b001,
		DMP_MVD_HI = 3'b010,
		DMP_DIR2 = 3'b011,
		DMP_PF_X = 3'b100,
		DMP_PF_Y = 3'b101,
		DMP_WB = 3'b110
	} dmp_state_t;
endpackage

// [design/dmp_rnd_if.sv]
// carrier between the executor and its accumulator rounder
`timescale 1ns/1ps
interface dmp_rnd_if #(parameter int ACC_W = 40);
	logic [ACC_W-1:0] acc; // accumulator chosen for write-back
	logic [15:0] word; // rounded upper word
	modport exec (output acc, input word);
	modport rnd (input acc, output word);
endinterface

// [verification/dmp_mem_model.sv]
// data memory partner model for the executor
`timescale 1ns/1ps
module dmp_mem_model
(
	input wire logic sys_clk,
	input wire logic mem_rd,
	input wire logic mem_wr,
	input wire logic [15:0] mem_addr,
	input wire logic [15:0] mem_wdata,
	output logic mem_ack,
	output logic [15:0] mem_rdata
);
	logic [15:0] mem [0:32767]; // word store, byte address bits 15:1
	int lag = 0; // wait cycles before ack, set by the bench
	int wait_r = 0; // cycles the current request has waited
	logic [15:0] last_r = 16'h0000; // last value on the read bus

	// ---------------------------------------------
	// answer side
	// ---------------------------------------------
	// ack once the wait has run out; the executor holds its request till then
	assign mem_ack = (mem_rd | mem_wr) && (wait_r >= lag);
	// outside an acked read the bus flips every cycle, so stale data never passes
	assign mem_rdata = (mem_ack && mem_rd) ? mem[mem_addr[15:1]] : ~last_r;

	// wait counter, stores and bus history
	always @(posedge sys_clk)
	begin
		last_r <= mem_rdata;
		if (mem_ack)
		begin
			wait_r <= 0;
			if (mem_wr)
				mem[mem_addr[15:1]] <= mem_wdata;
		end
		else if (mem_rd | mem_wr)
			wait_r <= wait_r + 1; // slow answer
	end
endmodule

// [verification/test_dword_move_page_prefetch_exec.sv]
// self-checking bench for the move, page load and prefetch executor
`timescale 1ns/1ps
module test_dword_move_page_prefetch_exec;
	logic sys_clk = 1'b0; // 100 mhz core clock
	logic rstn = 1'b0; // reset, active low
	logic instr_valid = 1'b0;
	logic [23:0] instr_word = 24'h000000;
	logic [39:0] accumulator_a = 40'h0000000000;
	logic [39:0] accumulator_b = 40'h0000000000;
	logic ld_en = 1'b0;
	logic [3:0] ld_idx = 4'h0;
	logic [15:0] ld_data = 16'h0000;
	logic [3:0] rd_idx = 4'h0;
	logic busy_r, done_r, illegal_r, mem_rd_r, mem_wr_r, mem_ack;
	logic [15:0] mem_addr_r, mem_wdata_r, mem_rdata, rd_data_r;
	logic [9:0] data_read_page_reg;
	logic [8:0] data_write_page_reg;
	logic [7:0] table_page_reg;
	logic last_ill; // illegal flag seen at completion
	int bad_count = 0;
	int tests_run = 0;

	always #5 sys_clk = ~sys_clk;

	dmp_exec #(.ACC_W(40)) i_dut (.sys_clk(sys_clk), .rstn(rstn), .instr_valid(instr_valid),
		.instr_word(instr_word), .accumulator_a(accumulator_a), .accumulator_b(accumulator_b),
		.mem_ack(mem_ack), .mem_rdata(mem_rdata), .ld_en(ld_en), .ld_idx(ld_idx), .ld_data(ld_data),
		.rd_idx(rd_idx), .busy_r(busy_r), .done_r(done_r), .illegal_r(illegal_r), .mem_rd_r(mem_rd_r),
		.mem_wr_r(mem_wr_r), .mem_addr_r(mem_addr_r), .mem_wdata_r(mem_wdata_r),
		.data_read_page_reg(data_read_page_reg), .data_write_page_reg(data_write_page_reg),
		.table_page_reg(table_page_reg), .rd_data_r(rd_data_r));

	dmp_mem_model i_mem (.sys_clk(sys_clk), .mem_rd(mem_rd_r), .mem_wr(mem_wr_r), .mem_addr(mem_addr_r),
		.mem_wdata(mem_wdata_r), .mem_ack(mem_ack), .mem_rdata(mem_rdata));

	// ---------------------------------------------
	// helpers
	// ---------------------------------------------
	// background memory content, distinct per word
	function automatic logic [15:0] pat(input logic [15:0] a);
		return ({1'b0, a[15:1]} * 16'h0003) ^ 16'h5a5a;
	endfunction

	task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string what);
		tests_run++;
		if (got !== exp)
		begin
			bad_count++;
			$display("unexpected at %0t: %s got %h want %h", $time, what, got, exp);
		end
	endtask

	task automatic chk_n(input int got, input int exp, input string what);
		tests_run++;
		if (got != exp)
		begin
			bad_count++;
			$display("unexpected at %0t: %s got %0d want %0d", $time, what, got, exp);
		end
	endtask

	// load one working register while idle
	task automatic ldw(input logic [3:0] idx, input logic [15:0] val);
		@(negedge sys_clk);
		ld_en = 1'b1;
		ld_idx = idx;
		ld_data = val;
		@(negedge sys_clk);
		ld_en = 1'b0;
	endtask

	// read back a working register and compare
	task automatic chk_w(input logic [3:0] idx, input logic [15:0] exp, input string what);
		@(negedge sys_clk);
		rd_idx = idx;
		@(negedge sys_clk);
		chk(rd_data_r, exp, what);
	endtask

	// offer one word, wait for done or illegal; exp_cnt 0 means any latency under the bound
	task automatic issue(input logic [23:0] word, input int exp_cnt, input string what);
		int n;
		n = 1;
		@(negedge sys_clk);
		instr_valid = 1'b1;
		instr_word = word;
		@(negedge sys_clk);
		instr_valid = 1'b0;
		while (done_r !== 1'b1 && illegal_r !== 1'b1 && n < 40)
		begin
			@(negedge sys_clk);
			n++;
		end
		last_ill = illegal_r;
		chk_n(busy_r === 1'b0, 1, what);
		if (exp_cnt > 0)
			chk_n(n, exp_cnt, what);
		else
			chk_n(n < 40, 1, what);
	endtask

	// ---------------------------------------------
	// scenarios
	// ---------------------------------------------
	task automatic t_direct;
		ldw(2, 16'h12fb);
		ldw(3, 16'h9877);
		ldw(6, 16'h9833);
		ldw(7, 16'hfcc6);
		issue(24'hbe0302, 2, "direct move");
		chk_w(6, 16'h12fb, "move low");
		chk_w(7, 16'h9877, "move high");
		chk_w(2, 16'h12fb, "source kept");
	endtask

	// every indirect mode, prompt and slow memory
	task automatic t_indirect;
		logic [15:0] ea, np;
		for (int m = 1; m <= 5; m++)
		begin
			i_mem.lag = (m % 2) ? 0 : 2;
			ldw(8, 16'h0a00);
			ea = (m == 4) ? 16'h09fc : ((m == 5) ? 16'h0a04 : 16'h0a00);
			np = (m == 1) ? 16'h0a00 : ((m == 2 || m == 4) ? 16'h09fc : 16'h0a04);
			issue({12'hbe0, 4'h1, 1'b0, m[2:0], 4'h8}, 0, "indirect move");
			chk_w(2, pat(ea), "low word at ea");
			chk_w(3, pat(ea + 16'h0002), "high word next");
			chk_w(8, np, "pointer by four");
		end
		i_mem.lag = 0;
	endtask

	task automatic t_pop;
		ldw(15, 16'h1004);
		issue(24'hbe004f, 0, "double pop");
		chk_w(0, pat(16'h1000), "pop low");
		chk_w(1, pat(16'h1002), "pop high");
		chk_w(15, 16'h1000, "stack down");
	endtask

	task automatic t_page;
		issue(24'hfec002, 1, "literal page");
		chk({6'h00, data_read_page_reg}, 16'h0002, "read page");
		// three literal loads on consecutive edges
		@(negedge sys_clk);
		instr_valid = 1'b1;
		instr_word = 24'hfec3ff;
		@(negedge sys_clk);
		instr_word = 24'hfec7ff;
		@(negedge sys_clk);
		instr_word = 24'hfecbff;
		@(negedge sys_clk);
		instr_valid = 1'b0;
		issue(24'hfecc00, 1, "no page");
		chk({6'h00, data_read_page_reg}, 16'h03ff, "read page ten");
		chk({7'h00, data_write_page_reg}, 16'h01ff, "write page nine");
		chk({8'h00, table_page_reg}, 16'h00ff, "table page eight");
		ldw(2, 16'habcd);
		issue(24'hfed002, 1, "reg read page");
		issue(24'hfed402, 1, "reg write page");
		issue(24'hfed802, 1, "reg table page");
		chk({6'h00, data_read_page_reg}, 16'h03cd, "reg read page");
		chk({7'h00, data_write_page_reg}, 16'h01cd, "reg write page");
		chk({8'h00, table_page_reg}, 16'h00cd, "reg table page");
	endtask

	// every x and y pointer step, x from w8 into w4, y from w11 into w7
	task automatic t_steps;
		logic [15:0] adj;
		for (int k = 0; k < 8; k++)
		begin
			if (k == 4)
				continue;
			i_mem.lag = k % 2;
			adj = (k < 4) ? 16'(2 * k) : 16'(2 * k - 16);
			ldw(8, 16'h1000);
			ldw(11, 16'h2000);
			issue({8'hc7, 6'h03, 1'b0, k[2:0], 1'b1, k[2:0], 2'h2}, 0, "prefetch");
			chk_w(4, pat(16'h1000), "x fetch");
			chk_w(7, pat(16'h2000), "y fetch");
			chk_w(8, 16'h1000 + adj, "x step");
			chk_w(11, 16'h2000 + adj, "y step");
		end
		i_mem.lag = 0;
	endtask

	task automatic t_store;
		accumulator_a = 40'h0032905968;
		accumulator_b = 40'h0098344500;
		ldw(9, 16'h0800);
		ldw(11, 16'h1900);
		i_mem.mem[16'h0400] = 16'h7811;
		i_mem.mem[16'h0c80] = 16'hb2af;
		issue(24'hc7ae28, 0, "store to reg");
		chk_w(6, 16'h7811, "x no step");
		chk_w(7, 16'hb2af, "y fetch");
		chk_w(9, 16'h0800, "x kept");
		chk_w(11, 16'h1904, "y plus four");
		chk_w(13, 16'h3290, "other acc");
		ldw(9, 16'h1200);
		ldw(11, 16'h2000);
		ldw(12, 16'h0024);
		ldw(13, 16'h2300);
		i_mem.mem[16'h0900] = 16'hbb00;
		i_mem.mem[16'h1012] = 16'h52ce;
		issue(24'hc70bf1, 0, "store to mem");
		chk_w(4, 16'hbb00, "x fetch");
		chk_w(6, 16'h52ce, "offset fetch");
		chk_w(9, 16'h11fe, "x minus two");
		chk_w(11, 16'h2000, "offset kept");
		chk_w(13, 16'h2302, "w13 plus two");
		chk(i_mem.mem[16'h1180], 16'h9834, "stored acc");
		issue(24'hc71312, 0, "x offset fetch");
		chk_w(5, pat(16'h1222), "x offset data");
		chk_w(9, 16'h11fe, "x offset kept");
		accumulator_b = 40'h0012348000;
		issue(24'hc70110, 0, "rounded store");
		chk_w(13, 16'h1235, "rounded up");
		issue(24'hc70112, 1, "no store");
		chk_w(13, 16'h1235, "w13 kept");
		issue(24'h000000, 0, "unknown word");
		chk_n(last_ill, 1, "illegal flag");
	endtask

	// ---------------------------------------------
	// verdict and run order
	// ---------------------------------------------
	task automatic complete_run;
		$display("checks %0d mismatches %0d", tests_run, bad_count);
		if (bad_count == 0 && tests_run > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask

	// watchdog: the whole run needs well under this
	initial
	begin
		repeat (20000) @(posedge sys_clk);
		bad_count++;
		$display("unexpected at %0t: watchdog ran out", $time);
		complete_run;
	end

	initial
	begin
		for (int i = 0; i < 32768; i++)
			i_mem.mem[i] = pat(16'(2 * i));
		repeat (10) @(negedge sys_clk);
		rstn = 1'b1;
		repeat (3) @(posedge sys_clk);
		t_direct;
		t_indirect;
		t_pop;
		t_page;
		t_steps;
		t_store;
		complete_run;
	end
endmodule
